// [core/fsv_supervisor.sv]
// Drive fault supervisor: classification, stall, supply, speed, heat
// Summary of operation
// RQ1 - Some conditions are classed by select masks, the rest always fault.
// RQ2 - Fault select gives a fault, warning alone a warning, none ignores.
// RQ3 - Speed feedback loss sits at position 0 of both masks.
// RQ4 - Speed feedback loss counts only when the feedback kind equals 2.
// RQ5 - Loss is a quadrature break or any of the four encoder wires missing.
// RQ6 - Motor stall sits at position 5 of both masks.
// RQ7 - Stall needs zero speed at status bit 12 and a nonzero limit word.
// RQ8 - Stall is reported only after both have held for the stall delay.
// RQ9 - The stall timer clears when either cause goes away early.
// RQ10 - Overload pending and trip sit at positions 3 and 4 of both masks.
// RQ11 - An analog supply outside 13 V to 18 V is always a fault.
// RQ12 - Speed beyond either limit plus the margin is always a fault.
// RQ13 - Overtemperature pending sits at position 1, set from 80 degrees.
// RQ14 - Heatsink outside -20 to 100 degrees is always a trip fault.
// RQ15 - The model adds current times 30 to heatsink, less 120, integrated.
// RQ16 - A prediction above 120 limits current, status bit 1 or 9.
`timescale 1ns/1ns
module fsv_supervisor #(
  parameter int STALL_TICK = fsv_pkg::STALL_TICK_CYC
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               enc_a,
  input  wire logic               enc_a_n,
  input  wire logic               enc_b,
  input  wire logic               enc_b_n,
  input  wire logic [2:0]         fdbk_device_kind,
  input  wire fsv_pkg::fsv_word_t fault_select_2,
  input  wire fsv_pkg::fsv_word_t warning_select_2,
  input  wire logic               fault_clear,
  input  wire fsv_pkg::fsv_word_t drive_status,
  input  wire fsv_pkg::fsv_word_t limit_status_in,
  input  wire fsv_pkg::fsv_word_t stall_delay,
  input  wire logic               motor_overload_pending,
  input  wire logic               motor_overload_trip,
  input  wire logic [15:0]        analog_supply_mv,
  input  wire logic signed [15:0] motor_speed,
  input  wire logic [15:0]        fwd_speed_limit,
  input  wire logic [15:0]        rev_speed_limit,
  input  wire logic [15:0]        overspeed_margin,
  input  wire logic signed [11:0] heatsink_temp,
  input  wire logic [15:0]        stator_current,
  input  wire logic               iq_neg,
  output fsv_pkg::fsv_word_t      fault_bits,
  output fsv_pkg::fsv_word_t      warning_bits,
  output logic                    analog_supply_fault,
  output logic                    overspeed_fault,
  output logic                    overtemp_trip_fault,
  output logic                    fault_any,
  output logic                    warning_any,
  output fsv_pkg::fsv_word_t      limit_status_out,
  output logic                    current_foldback
);
  import fsv_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  localparam logic [23:0] TICK_LAST = 24'(STALL_TICK - 1);

  fsv_state_t q;
  fsv_state_t d;

  logic               enc_loss;
  logic               ntc_pos;
  logic               ntc_neg;
  fsv_word_t          cond;
  fsv_word_t          new_fault;
  fsv_word_t          new_warn;
  logic               zero_speed;
  logic               limit_any;
  logic               stall_both;
  logic               stall_cond;
  logic               supply_bad;
  logic               ovspd_now;
  logic               ovt_trip_now;
  logic               ovt_pend_now;
  logic signed [17:0] spd_s;
  logic signed [17:0] fwd_lim;
  logic signed [17:0] rev_lim;

  // ************************************************************
  // Feedback and thermal submodules
  // ************************************************************
  fsv_enc_check u_enc (
    .clk     (clk),
    .srst    (srst),
    .enc_a   (enc_a),
    .enc_a_n (enc_a_n),
    .enc_b   (enc_b),
    .enc_b_n (enc_b_n),
    .loss    (enc_loss)
  );

  fsv_ntc_model u_ntc (
    .clk            (clk),
    .srst           (srst),
    .stator_current (stator_current),
    .heatsink_temp  (heatsink_temp),
    .iq_neg         (iq_neg),
    .limit_pos      (ntc_pos),
    .limit_neg      (ntc_neg)
  );

  always_comb begin
    limit_status_out                = FLAGS_RST;
    limit_status_out[POS_LIM_NTC_P] = ntc_pos; // RQ16
    limit_status_out[POS_LIM_NTC_N] = ntc_neg; // RQ16
  end
  assign current_foldback = ntc_pos || ntc_neg;

  // ************************************************************
  // Condition detection
  // ************************************************************
  // Our own foldback counts as a limit for stall purposes too
  assign zero_speed = drive_status[POS_ZERO_SPEED]; // RQ7
  assign limit_any  = (limit_status_in | limit_status_out) != FLAGS_RST;
  assign stall_both = zero_speed && limit_any; // RQ7
  assign stall_cond = stall_both && (q.stall_cnt >= stall_delay); // RQ8

  assign supply_bad = (analog_supply_mv < SUPPLY_MIN_MV)
                   || (analog_supply_mv > SUPPLY_MAX_MV); // RQ11

  assign spd_s   = 18'(motor_speed);
  assign fwd_lim = $signed({2'h0, fwd_speed_limit})
                 + $signed({2'h0, overspeed_margin}); // RQ12
  assign rev_lim = -($signed({2'h0, rev_speed_limit})
                 + $signed({2'h0, overspeed_margin})); // RQ12
  assign ovspd_now = (spd_s > fwd_lim) || (spd_s < rev_lim); // RQ12

  assign ovt_pend_now = heatsink_temp >= TEMP_PEND_C; // RQ13
  assign ovt_trip_now = (heatsink_temp < TEMP_TRIP_LO_C)
                     || (heatsink_temp > TEMP_TRIP_HI_C); // RQ14

  always_comb begin
    cond                = FLAGS_RST;
    cond[POS_FDBK_LOSS] = enc_loss
                       && (fdbk_device_kind == FDBK_KIND_ENCODER); // RQ3 RQ4
    cond[POS_OVT_PEND]  = ovt_pend_now; // RQ13
    cond[POS_OVLD_PEND] = motor_overload_pending; // RQ10
    cond[POS_OVLD_TRIP] = motor_overload_trip; // RQ10
    cond[POS_STALL]     = stall_cond; // RQ6
  end

  // Fault select wins over warning select for the same bit
  assign new_fault = cond & fault_select_2; // RQ2
  assign new_warn  = cond & warning_select_2 & ~fault_select_2; // RQ2

  // ************************************************************
  // State update
  // ************************************************************
  always_comb begin
    d = q;
    // A condition present in the clearing cycle stays latched
    d.fault    = (fault_clear ? FLAGS_RST : q.fault) | new_fault; // RQ1
    d.warn     = (fault_clear ? FLAGS_RST : q.warn) | new_warn; // RQ2
    d.supply   = (q.supply && !fault_clear) || supply_bad; // RQ11
    d.ovspd    = (q.ovspd && !fault_clear) || ovspd_now; // RQ12
    d.ovt_trip = (q.ovt_trip && !fault_clear) || ovt_trip_now; // RQ14
    d.f_any    = (d.fault != FLAGS_RST) || d.supply || d.ovspd
              || d.ovt_trip; // RQ1
    d.w_any    = d.warn != FLAGS_RST;
    // Delay counts in ticks; saturates so a long stall stays reported
    if (!stall_both) begin
      d.tick      = 24'h000000; // RQ9
      d.stall_cnt = FLAGS_RST; // RQ9
    end else if (q.tick == TICK_LAST) begin
      d.tick = 24'h000000;
      if (q.stall_cnt < stall_delay) begin
        d.stall_cnt = q.stall_cnt + 16'h0001; // RQ8
      end
    end else begin
      d.tick = q.tick + 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign fault_bits          = q.fault;
  assign warning_bits        = q.warn;
  assign analog_supply_fault = q.supply;
  assign overspeed_fault     = q.ovspd;
  assign overtemp_trip_fault = q.ovt_trip;
  assign fault_any           = q.f_any;
  assign warning_any         = q.w_any;

  // ************************************************************
  // Checks
  // ************************************************************
  a_fault_select: assert property (@(posedge clk) disable iff (srst) // RQ2
    (new_fault != FLAGS_RST) |=>
      ((fault_bits & $past(new_fault)) == $past(new_fault)) && fault_any)
    else $error("selected condition did not latch a fault");

  a_warn_only: assert property (@(posedge clk) disable iff (srst) // RQ2
    fault_clear |=> ((fault_bits & ~$past(fault_select_2)) == FLAGS_RST)
      && ((warning_bits & $past(fault_select_2)) == FLAGS_RST))
    else $error("unselected bit reported after clear");

  a_fdbk_map: assert property (@(posedge clk) disable iff (srst) // RQ3
    enc_loss && (fdbk_device_kind == FDBK_KIND_ENCODER)
      && fault_select_2[POS_FDBK_LOSS] |=> fault_bits[POS_FDBK_LOSS])
    else $error("feedback loss not at position 0");

  a_fdbk_kind: assert property (@(posedge clk) disable iff (srst) // RQ4
    fault_clear && (fdbk_device_kind != FDBK_KIND_ENCODER) |=>
      !fault_bits[POS_FDBK_LOSS] && !warning_bits[POS_FDBK_LOSS])
    else $error("feedback loss without encoder fitted");

  a_stall_cause: assert property (@(posedge clk) disable iff (srst) // RQ7
    cond[POS_STALL] |-> drive_status[POS_ZERO_SPEED] && limit_any)
    else $error("stall without zero speed and limit");

  a_stall_wait: assert property (@(posedge clk) disable iff (srst) // RQ8
    $rose(stall_both) && (stall_delay != FLAGS_RST) |-> !stall_cond)
    else $error("stall reported before the delay");

  a_stall_reset: assert property (@(posedge clk) disable iff (srst) // RQ9
    !stall_both |=> (q.stall_cnt == FLAGS_RST) && (q.tick == 24'h000000))
    else $error("stall timer not cleared");

  a_supply_win: assert property (@(posedge clk) disable iff (srst) // RQ11
    supply_bad |=> analog_supply_fault && fault_any)
    else $error("supply window fault missed");

  a_nc_hold: assert property (@(posedge clk) disable iff (srst) // RQ1
    analog_supply_fault && !fault_clear |=> analog_supply_fault)
    else $error("fixed fault dropped without clear");

  a_overspeed: assert property (@(posedge clk) disable iff (srst) // RQ12
    ovspd_now |=> overspeed_fault)
    else $error("overspeed fault missed");

  a_ovt_pend: assert property (@(posedge clk) disable iff (srst) // RQ13
    (heatsink_temp >= TEMP_PEND_C) && fault_select_2[POS_OVT_PEND]
      |=> fault_bits[POS_OVT_PEND])
    else $error("overtemperature pending missed");

  a_ovt_trip: assert property (@(posedge clk) disable iff (srst) // RQ14
    ((heatsink_temp > TEMP_TRIP_HI_C) || (heatsink_temp < TEMP_TRIP_LO_C))
      |=> overtemp_trip_fault)
    else $error("overtemperature trip missed");

  a_warn_latch: assert property ( // RQ2
    (new_warn != FLAGS_RST)
      |=> (warning_bits & $past(new_warn)) == $past(new_warn))
    else $error("warning-only bit did not latch");

  a_warn_clear: assert property ( // RQ2
    fault_clear
      |=> (warning_bits & ~$past(warning_select_2)) == FLAGS_RST)
    else $error("unselected warning after clear");

  a_fixed_any: assert property ( // RQ1
    analog_supply_fault || overspeed_fault
      || overtemp_trip_fault |-> fault_any)
    else $error("fixed fault missing from summary");

  a_supply_clear: assert property ( // RQ11
    fault_clear && !supply_bad
      |=> !analog_supply_fault)
    else $error("supply fault not cleared");

  a_stall_map: assert property ( // RQ6
    stall_cond && fault_select_2[POS_STALL]
      |=> fault_bits[POS_STALL])
    else $error("stall not at position 5");

  a_ovld_pend: assert property ( // RQ10
    motor_overload_pending && fault_select_2[POS_OVLD_PEND]
      |=> fault_bits[POS_OVLD_PEND])
    else $error("overload pending not at position 3");

  a_ovld_trip: assert property ( // RQ10
    motor_overload_trip && fault_select_2[POS_OVLD_TRIP]
      |=> fault_bits[POS_OVLD_TRIP])
    else $error("overload trip not at position 4");

  a_ovspd_hold: assert property ( // RQ12
    overspeed_fault && !fault_clear
      |=> overspeed_fault)
    else $error("overspeed fault dropped without clear");

  a_ovt_hold: assert property ( // RQ14
    overtemp_trip_fault && !fault_clear
      |=> overtemp_trip_fault)
    else $error("overtemperature trip dropped without clear");

  a_stall_zero: assert property ( // RQ9
    !drive_status[POS_ZERO_SPEED]
      |=> q.stall_cnt == FLAGS_RST)
    else $error("stall timer kept without zero speed");

endmodule : fsv_supervisor

// [pkg/fsv_pkg.sv]
// Shared constants and types of the drive fault supervisor
package fsv_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_MHZ        = 50;
  localparam int WIRE_LOSS_US   = 10;
  localparam int WIRE_LOSS_CYC  = WIRE_LOSS_US * CLK_MHZ;
  localparam int STALL_TICK_US  = 1000;
  localparam int STALL_TICK_CYC = STALL_TICK_US * CLK_MHZ;

  // ************************************************************
  // Words and reset values
  // ************************************************************
  typedef logic [15:0] fsv_word_t;
  localparam fsv_word_t FLAGS_RST = 16'h0000;

  // ************************************************************
  // Bit positions
  // ************************************************************
  localparam int POS_FDBK_LOSS  = 0;
  localparam int POS_OVT_PEND   = 1;
  localparam int POS_OVLD_PEND  = 3;
  localparam int POS_OVLD_TRIP  = 4;
  localparam int POS_STALL      = 5;
  localparam int POS_ZERO_SPEED = 12;
  localparam int POS_LIM_NTC_P  = 1;
  localparam int POS_LIM_NTC_N  = 9;

  // ************************************************************
  // Thresholds
  // ************************************************************
  localparam logic [2:0]         FDBK_KIND_ENCODER = 3'h2;
  localparam logic [15:0]        SUPPLY_MIN_MV     = 16'h32c8;
  localparam logic [15:0]        SUPPLY_MAX_MV     = 16'h4650;
  localparam logic signed [11:0] TEMP_PEND_C       = 12'sh050;
  localparam logic signed [11:0] TEMP_TRIP_LO_C    = -12'sh014;
  localparam logic signed [11:0] TEMP_TRIP_HI_C    = 12'sh064;

  // ************************************************************
  // Thermal foldback model, current in Q4.12 per unit
  // ************************************************************
  localparam int                 I_FRAC        = 12;
  localparam logic [4:0]         NTC_RISE_C    = 5'h1e;
  localparam logic signed [27:0] NTC_LIMIT_Q   = 28'sh0078000;
  localparam int                 NTC_INT_SHIFT = 8;
  localparam logic [23:0]        NTC_ACC_MAX   = 24'h7fffff;

  // ************************************************************
  // Supervisor state
  // ************************************************************
  typedef struct packed {
    fsv_word_t   fault;
    fsv_word_t   warn;
    logic        supply;
    logic        ovspd;
    logic        ovt_trip;
    logic        f_any;
    logic        w_any;
    logic [23:0] tick;
    fsv_word_t   stall_cnt;
  } fsv_state_t;
  localparam fsv_state_t STATE_RST = '0;

endpackage : fsv_pkg

// [core/fsv_enc_check.sv]
// Encoder wire presence and quadrature checker
`timescale 1ns/1ns
module fsv_enc_check (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic enc_a,
  input  wire logic enc_a_n,
  input  wire logic enc_b,
  input  wire logic enc_b_n,
  output logic      loss
);
  import fsv_pkg::*;

  localparam logic [9:0] MISS_LAST = 10'(WIRE_LOSS_CYC);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [2:0] vld;
    logic [1:0] prev;
    logic [9:0] miss;
    logic       loss;
  } fsv_enc_t;

  fsv_enc_t q;
  fsv_enc_t d;
  logic [1:0] cur;
  logic       pair_bad;
  logic       quad_err;

  // Pin order in the stages: a, a_n, b, b_n
  assign cur      = {q.s2[3], q.s2[1]};
  assign pair_bad = (q.s2[3] == q.s2[2]) || (q.s2[1] == q.s2[0]); // RQ5
  assign quad_err = q.vld[2] && ((cur ^ q.prev) == 2'b11); // RQ5

  always_comb begin
    d      = q;
    d.s1   = {enc_a, enc_a_n, enc_b, enc_b_n};
    d.s2   = q.s1;
    d.vld  = {q.vld[1:0], 1'b1};
    d.prev = cur;
    // A wire must read equal to its complement for a while; a lone
    // glitch on a long cable is not a missing wire
    if (!pair_bad || !q.vld[2]) begin
      d.miss = 10'h000;
    end else if (q.miss != MISS_LAST) begin
      d.miss = q.miss + 10'h001;
    end
    d.loss = quad_err || (q.miss == MISS_LAST); // RQ5
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign loss = q.loss;

  a_quad_jump: assert property (@(posedge clk) disable iff (srst) // RQ5
    quad_err |=> loss)
    else $error("quadrature jump not reported");

endmodule : fsv_enc_check

// [core/fsv_ntc_model.sv]
// Thermal foldback model with integrated temperature error
`timescale 1ns/1ns
module fsv_ntc_model (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic [15:0]        stator_current,
  input  wire logic signed [11:0] heatsink_temp,
  input  wire logic               iq_neg,
  output logic                    limit_pos,
  output logic                    limit_neg
);
  import fsv_pkg::*;

  typedef struct packed {
    logic [23:0] acc;
    logic        lim_pos;
    logic        lim_neg;
  } fsv_ntc_t;

  fsv_ntc_t q;
  fsv_ntc_t d;
  logic [20:0]        rise;
  logic signed [27:0] err;
  logic signed [27:0] inc;
  logic signed [27:0] sum;

  // Rise plus heatsink minus the ceiling, all in Q.12 degrees
  assign rise = 21'(stator_current) * 21'(NTC_RISE_C); // RQ15
  assign err  = $signed({7'h00, rise}) + (28'(heatsink_temp) <<< I_FRAC)
              - NTC_LIMIT_Q; // RQ15
  assign inc  = err >>> NTC_INT_SHIFT;
  assign sum  = $signed({4'h0, q.acc}) + inc;

  always_comb begin
    d = q;
    if (sum < 28'sh0000000) begin // RQ15
      d.acc = 24'h000000;
    end else if (sum > $signed({4'h0, NTC_ACC_MAX})) begin
      d.acc = NTC_ACC_MAX;
    end else begin
      d.acc = sum[23:0];
    end
    d.lim_pos = (q.acc != 24'h000000) && !iq_neg; // RQ16
    d.lim_neg = (q.acc != 24'h000000) && iq_neg; // RQ16
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign limit_pos = q.lim_pos;
  assign limit_neg = q.lim_neg;

  a_ntc_grow: assert property (@(posedge clk) disable iff (srst) // RQ15
    (inc > 28'sh0000000) && (q.acc < 24'h400000) |=> q.acc > $past(q.acc))
    else $error("model did not integrate a positive error");

  a_ntc_limit: assert property (@(posedge clk) disable iff (srst) // RQ16
    (q.acc != 24'h000000) |=> (limit_pos ^ limit_neg)
      && (limit_neg == $past(iq_neg)))
    else $error("foldback direction bit wrong");

endmodule : fsv_ntc_model

// [tb/fsv_enc_model.sv]
// Encoder stand-in for the motor side of the fault supervisor
`timescale 1ns/1ns
module fsv_enc_model (
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  output logic            enc_a,
  output logic            enc_a_n,
  output logic            enc_b,
  output logic            enc_b_n
);
  // Mode 0 stopped, 1 turning, 2 channels jump, 3 A complement lost
  logic [1:0] div_q   = 2'h0;
  logic [1:0] phase_q = 2'h0;

  always_ff @(posedge clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3 && mode != 2'h0) begin
      // Skipping a state flips both channels at once
      phase_q <= phase_q + ((mode == 2'h2) ? 2'h2 : 2'h1);
    end
  end

  assign enc_a   = phase_q[1];
  assign enc_b   = phase_q[1] ^ phase_q[0];
  // A broken wire settles at its partner's level at the receiver
  assign enc_a_n = (mode == 2'h3) ? enc_a : ~enc_a;
  assign enc_b_n = ~enc_b;
endmodule : fsv_enc_model

// [tb/drive_fault_supervisor_tb.sv]
// Self-checking bench for the drive fault supervisor
`timescale 1ns/1ns
module drive_fault_supervisor_tb;
  import fsv_pkg::*;

  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic               clk         = 1'b0;
  logic               srst        = 1'b1;
  logic               fault_clear = 1'b0;
  logic               iq_neg      = 1'b0;
  logic               ovld_pend   = 1'b0;
  logic               ovld_trip   = 1'b0;
  logic [2:0]         kind        = 3'h2;
  logic [1:0]         enc_mode    = 2'h0;
  fsv_word_t          fsel        = 16'h0000;
  fsv_word_t          wsel        = 16'h0000;
  fsv_word_t          dstat       = 16'h0000;
  fsv_word_t          lim_in      = 16'h0000;
  fsv_word_t          sdelay      = 16'h0004;
  logic [15:0]        supply      = 16'h3a98;
  logic [15:0]        cur         = 16'h0000;
  logic [15:0]        rev         = 16'h07d0;
  logic [15:0]        fwd         = 16'h03e8;
  logic [15:0]        margin      = 16'h0064;
  logic signed [15:0] speed       = 16'sh0000;
  logic signed [11:0] temp        = 12'sh019;
  logic               enc_a, enc_a_n, enc_b, enc_b_n;
  fsv_word_t          fbits, wbits, lim_out;
  logic               sup_f, ovs_f, ovt_f, f_any, w_any, fold;
  int                 errors      = 0;
  int                 check_count = 0;
  logic [15:0]        sup_tab [4] = '{16'h32c7, 16'h32c8, 16'h4650,
                                      16'h4651};
  logic signed [11:0] tmp_tab [6] = '{12'sh04f, 12'sh050, 12'sh064,
                                      12'sh065, 12'shfec, 12'shfeb};
  logic signed [15:0] spd_tab [4] = '{16'sh044c, 16'sh044d, 16'shf7cc,
                                      16'shf7cb};

  always #10 clk = ~clk;

  // Short stall tick keeps the stall scenarios to a few dozen cycles
  fsv_supervisor #(.STALL_TICK(4)) uut (
    .clk                    (clk),
    .srst                   (srst),
    .enc_a                  (enc_a),
    .enc_a_n                (enc_a_n),
    .enc_b                  (enc_b),
    .enc_b_n                (enc_b_n),
    .fdbk_device_kind       (kind),
    .fault_select_2         (fsel),
    .warning_select_2       (wsel),
    .fault_clear            (fault_clear),
    .drive_status           (dstat),
    .limit_status_in        (lim_in),
    .stall_delay            (sdelay),
    .motor_overload_pending (ovld_pend),
    .motor_overload_trip    (ovld_trip),
    .analog_supply_mv       (supply),
    .motor_speed            (speed),
    .fwd_speed_limit        (fwd),
    .rev_speed_limit        (rev),
    .overspeed_margin       (margin),
    .heatsink_temp          (temp),
    .stator_current         (cur),
    .iq_neg                 (iq_neg),
    .fault_bits             (fbits),
    .warning_bits           (wbits),
    .analog_supply_fault    (sup_f),
    .overspeed_fault        (ovs_f),
    .overtemp_trip_fault    (ovt_f),
    .fault_any              (f_any),
    .warning_any            (w_any),
    .limit_status_out       (lim_out),
    .current_foldback       (fold)
  );

  fsv_enc_model enc (
    .clk     (clk),
    .mode    (enc_mode),
    .enc_a   (enc_a),
    .enc_a_n (enc_a_n),
    .enc_b   (enc_b),
    .enc_b_n (enc_b_n)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string name, input fsv_word_t exp,
                     input fsv_word_t got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Caller removes the condition first, since a live cause wins
  task automatic clr();
    @(posedge clk);
    fault_clear <= 1'b1;
    @(posedge clk);
    fault_clear <= 1'b0;
    tick(2);
  endtask : clr

  task automatic finish_test();
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    chk("fault_bits", FLAGS_RST, fbits);
    chk("warning_bits", FLAGS_RST, wbits);
    chk("limit_status_out", FLAGS_RST, lim_out);
    chk("flags", 16'h0000,
        {10'h000, sup_f, ovs_f, ovt_f, f_any, w_any, fold});
  endtask : t_reset

  task automatic t_supply();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      supply <= sup_tab[i];
      tick(3);
      chk("analog_supply_fault", 16'(i == 0 || i == 3), sup_f);
      chk("fault_any", 16'(i == 0 || i == 3), f_any);
      @(posedge clk);
      supply <= 16'h3a98;
      clr();
    end
  endtask : t_supply

  task automatic t_classify();
    int         b;
    logic [1:0] aw;
    for (int k = 0; k < 8; k++) begin
      b = k[2] ? POS_OVLD_TRIP : POS_OVLD_PEND;
      aw = {k[1], k[1:0] == 2'h1};
      @(posedge clk);
      fsel <= 16'(k[1]) << b;
      wsel <= 16'(k[0]) << b;
      ovld_pend <= ~k[2];
      ovld_trip <= k[2];
      tick(3);
      chk("fault_bits", 16'(k[1]) << b, fbits);
      chk("warning_bits", 16'(aw[0]) << b, wbits);
      chk("any", 16'(aw), {14'h0, f_any, w_any});
      @(posedge clk);
      ovld_pend <= 1'b0;
      ovld_trip <= 1'b0;
      clr();
    end
  endtask : t_classify

  task automatic t_temp();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      fsel <= 16'h0002;
      temp <= tmp_tab[i];
      tick(3);
      chk("overtemp_pending", 16'(i >= 1 && i <= 3) << 1, fbits);
      chk("overtemp_trip", 16'(i == 3 || i == 5), ovt_f);
      @(posedge clk);
      temp <= 12'sh019;
      clr();
    end
  endtask : t_temp

  task automatic t_speed();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      speed <= spd_tab[i];
      tick(3);
      chk("overspeed_fault", 16'(i[0]), ovs_f);
      @(posedge clk);
      speed <= 16'sh0000;
      clr();
    end
  endtask : t_speed

  task automatic t_stall();
    @(posedge clk);
    fsel <= 16'h0020;
    dstat <= 16'h1000;
    tick(40);
    chk("stall_zero_speed_only", 16'h0000, fbits);
    @(posedge clk);
    dstat <= 16'hefff;
    lim_in <= 16'h0100;
    tick(40);
    chk("stall_limit_only", 16'h0000, fbits);
    @(posedge clk);
    dstat <= 16'h1000;
    tick(10);
    chk("stall_early", 16'h0000, fbits);
    @(posedge clk);
    lim_in <= 16'h0000;
    @(posedge clk);
    lim_in <= 16'h0100;
    tick(12);
    chk("stall_restart", 16'h0000, fbits);
    tick(4);
    chk("stall_before_delay", 16'h0000, fbits);
    tick(1);
    chk("stall_fault", 16'h0020, fbits);
    @(posedge clk);
    dstat <= 16'h0000;
    lim_in <= 16'h0000;
    clr();
  endtask : t_stall

  task automatic t_enc();
    @(posedge clk);
    fsel <= 16'h0001;
    enc_mode <= 2'h1;
    tick(100);
    chk("enc_turning", 16'h0000, fbits);
    @(posedge clk);
    enc_mode <= 2'h2;
    tick(20);
    chk("enc_quadrature_loss", 16'h0001, fbits);
    @(posedge clk);
    enc_mode <= 2'h1;
    kind <= 3'h1;
    clr();
    @(posedge clk);
    enc_mode <= 2'h2;
    tick(20);
    chk("enc_not_fitted", 16'h0000, fbits);
    @(posedge clk);
    // Let jumps drain from the synchroniser before re-arming
    enc_mode <= 2'h1;
    tick(8);
    @(posedge clk);
    kind <= 3'h2;
    enc_mode <= 2'h3;
    tick(450);
    chk("enc_wire_early", 16'h0000, fbits);
    tick(80);
    chk("enc_wire_missing", 16'h0001, fbits);
    @(posedge clk);
    enc_mode <= 2'h0;
    clr();
  endtask : t_enc

  task automatic t_fold();
    @(posedge clk);
    cur <= 16'h2000;
    temp <= 12'sh03b;
    tick(50);
    chk("foldback_below", 16'h0000, lim_out);
    @(posedge clk);
    temp <= 12'sh03d;
    tick(5);
    chk("foldback_pos", 16'h0002, lim_out);
    chk("current_foldback", 16'h0001, fold);
    @(posedge clk);
    iq_neg <= 1'b1;
    tick(3);
    chk("foldback_neg", 16'h0200, lim_out);
    @(posedge clk);
    cur <= 16'h0000;
    temp <= 12'sh019;
    iq_neg <= 1'b0;
    tick(20);
    chk("foldback_released", 16'h0000, lim_out);
  endtask : t_fold

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    tick(4);
    t_reset();
    t_supply();
    t_classify();
    t_temp();
    t_speed();
    t_stall();
    t_enc();
    t_fold();
    finish_test();
  end

  initial begin
    // Run needs about 1100 cycles; eighteen times that means a hang
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule : drive_fault_supervisor_tb
